/* verilog/rpct_timer.sv */
// Two reloadable PWM/capture timers with an APB register slave
// ----------------------------------------------------------------
// ----------------------------------------------------------------
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "rpct_regs.svh"
module rpct_timer
   import rpct_pkg::*;
#(
   parameter int NUM_TMR = 2
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Timer pins
   input wire logic [NUM_TMR-1:0] tmr_in,
   output logic [NUM_TMR-1:0] tmr_out,
   output logic [NUM_TMR-1:0] tmr_comp_out,
   output logic [NUM_TMR-1:0] tmr_comp_oe,
   // Interrupts
   output logic [NUM_TMR-1:0] tmr_irq_pulse,
   output logic irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      rpct_tmr_t [NUM_TMR-1:0] t;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [NUM_TMR-1:0] sts;
      logic [NUM_TMR-1:0] msk;
      logic irq;
   } rpct_state_t;

   rpct_state_t st;
   rpct_state_t next_st;

   // Next-state logic for bus, timers and interrupts
   always_comb begin
      logic access;
      logic wr;
      logic hit;
      logic [7:0] wb;
      logic [7:0] rb;
      logic [11:0] base;
      rpct_mode_t md;
      logic tick;
      logic pin_rise;
      logic pin_edge;
      logic at_reload;
      logic capt;
      logic [6:0] div;
      logic tout;
      logic ev;
      next_st = st;
      access = psel && penable && !st.ready;
      // Write lands at the edge where the master samples pready high
      wr = psel && penable && pwrite && st.ready;
      wb = pwdata[7:0];
      rb = `RPCT_RST_BYTE;
      hit = 1'b0;
      base = 12'h000;
      md = RPCT_ONE_SHOT;
      tick = 1'b0;
      pin_rise = 1'b0;
      pin_edge = 1'b0;
      at_reload = 1'b0;
      capt = 1'b0;
      div = 7'h00;
      tout = 1'b0;
      ev = 1'b0;
      // Bus answers one cycle after the access phase begins
      next_st.ready = access;
      next_st.err = 1'b0;
      next_st.rdata = 32'h0000_0000;
      for (int i = 0; i < NUM_TMR; i++) begin
         base = (i == 0) ? `RPCT_T0_MATCH_HIGH : `RPCT_T1_MATCH_HIGH;
         next_st.t[i].irq = 1'b0;
         // Register access, one byte per consecutive address
         if (paddr == base) begin
            hit = 1'b1;
            rb = st.t[i].match[15:8];
            if (wr) next_st.t[i].match[15:8] = wb;
         end
         if (paddr == base + 12'h001) begin
            hit = 1'b1;
            rb = st.t[i].match[7:0];
            if (wr) next_st.t[i].match[7:0] = wb;
         end
         if (paddr == base + 12'h002) begin
            hit = 1'b1;
            rb = st.t[i].ctl0;
            if (wr) begin
               next_st.t[i].ctl0 = (wb & `RPCT_C0_WMASK) |
                  (st.t[i].ctl0 & ~`RPCT_C0_WMASK);
            end
         end
         if (paddr == base + 12'h003) begin
            hit = 1'b1;
            rb = st.t[i].ctl1;
            if (wr) next_st.t[i].ctl1 = wb;
         end
         if (paddr == base + 12'h004) begin
            hit = 1'b1;
            rb = st.t[i].reload[15:8];
            if (wr) next_st.t[i].reload[15:8] = wb;
         end
         if (paddr == base + 12'h005) begin
            hit = 1'b1;
            rb = st.t[i].reload[7:0];
            if (wr) next_st.t[i].reload[7:0] = wb;
         end
         if (paddr == base + 12'h006) begin
            hit = 1'b1;
            rb = st.t[i].count[15:8];
            if (wr) next_st.t[i].count[15:8] = wb;
         end
         if (paddr == base + 12'h007) begin
            hit = 1'b1;
            rb = st.t[i].count[7:0];
            if (wr) next_st.t[i].count[7:0] = wb;
         end
         // Mode from the high bit above the low field
         md = rpct_mode_t'({st.t[i].ctl0[`RPCT_C0_MODE_MSB],
            st.t[i].ctl1[`RPCT_C1_MODE_HI:`RPCT_C1_MODE_LO]});
         // Input pin edges, sampled once per clock
         next_st.t[i].pin_q = tmr_in[i];
         pin_edge = tmr_in[i] ^ st.t[i].pin_q;
         pin_rise = pin_edge && (tmr_in[i] ^ st.t[i].ctl1[`RPCT_C1_POL]);
         // Prescaler: ratio 2**field, 1 to 128
         div = 7'((8'h01 << st.t[i].ctl1[`RPCT_C1_PRE_HI:`RPCT_C1_PRE_LO]) - 8'h01);
         if (st.t[i].ctl1[`RPCT_C1_EN]) begin
            if (md == RPCT_COUNTER) begin
               tick = pin_rise;
            end else if (md == RPCT_GATED) begin
               tick = st.t[i].pre == div && tmr_in[i];
            end else begin
               tick = st.t[i].pre == div;
            end
            if (st.t[i].pre == div || (md == RPCT_GATED && !tmr_in[i])) begin
               next_st.t[i].pre = 7'h00;
            end else begin
               next_st.t[i].pre = st.t[i].pre + 7'h01;
            end
         end else begin
            next_st.t[i].pre = 7'h00;
         end
         // Capture on pin edge in capture modes
         capt = st.t[i].ctl1[`RPCT_C1_EN] && pin_rise &&
            (md == RPCT_CAPTURE || md == RPCT_CAPT_CMP) && md != RPCT_PWM_DUAL;
         at_reload = tick && st.t[i].count == st.t[i].reload;
         if (capt) begin
            next_st.t[i].match = st.t[i].count;
         end
         if (tick) begin
            if (at_reload || (md == RPCT_CAPT_CMP && capt)) begin
               next_st.t[i].count = `RPCT_START_COUNT;
               if (md == RPCT_ONE_SHOT) next_st.t[i].ctl1[`RPCT_C1_EN] = 1'b0;
            end else begin
               next_st.t[i].count = st.t[i].count + 16'h0001;
            end
         end
         // PWM toggles on match, reset to polarity on reload
         if (at_reload && (md == RPCT_PWM_SINGLE || md == RPCT_PWM_DUAL)) begin
            next_st.t[i].pwm = st.t[i].ctl1[`RPCT_C1_POL];
         end else if (tick && st.t[i].count == st.t[i].match &&
               md != RPCT_CAPTURE && md != RPCT_CAPT_CMP) begin
            next_st.t[i].pwm = ~st.t[i].pwm;
         end else if (!st.t[i].ctl1[`RPCT_C1_EN]) begin
            next_st.t[i].pwm = st.t[i].ctl1[`RPCT_C1_POL];
         end
         // Deadband sequencer delays each rising edge
         tout = st.t[i].pwm;
         unique case (st.t[i].db_st)
            RPCT_DB_IDLE: begin
               next_st.t[i].out_a = 1'b0;
               next_st.t[i].out_b = 1'b0;
               if (st.t[i].out_a != tout || st.t[i].out_b != ~tout) begin
                  next_st.t[i].db_cnt = st.t[i].ctl0[`RPCT_C0_DB_HI:`RPCT_C0_DB_LO];
                  next_st.t[i].db_st = RPCT_DB_WAIT;
               end
            end
            RPCT_DB_WAIT: begin
               if (st.t[i].db_cnt == 3'h0) begin
                  next_st.t[i].out_a = tout;
                  next_st.t[i].out_b = ~tout;
                  next_st.t[i].db_st = RPCT_DB_RUN;
               end else begin
                  next_st.t[i].db_cnt = st.t[i].db_cnt - 3'h1;
               end
            end
            RPCT_DB_RUN: begin
               if (st.t[i].out_a != tout) begin
                  next_st.t[i].out_a = 1'b0;
                  next_st.t[i].out_b = 1'b0;
                  next_st.t[i].db_cnt = st.t[i].ctl0[`RPCT_C0_DB_HI:`RPCT_C0_DB_LO];
                  next_st.t[i].db_st = RPCT_DB_WAIT;
               end
            end
            default: begin
               next_st.t[i].db_st = RPCT_DB_IDLE;
            end
         endcase
         // Interrupt events filtered by configuration
         unique case (st.t[i].ctl0[`RPCT_C0_CFG_HI:`RPCT_C0_CFG_LO])
            `RPCT_CFG_CAPTURE: ev = capt;
            `RPCT_CFG_RELOAD: ev = at_reload;
            default: ev = capt || at_reload;
         endcase
         if (ev) begin
            next_st.t[i].irq = 1'b1;
            next_st.t[i].ctl0[`RPCT_C0_CAP] = capt;
         end
      end
      // Interrupt status and mask
      if (paddr == `RPCT_IRQ_STATUS) begin
         hit = 1'b1;
         rb = 8'(st.sts);
         if (wr) next_st.sts = st.sts & ~wb[NUM_TMR-1:0];
      end
      if (paddr == `RPCT_IRQ_MASK) begin
         hit = 1'b1;
         rb = 8'(st.msk);
         if (wr) next_st.msk = wb[NUM_TMR-1:0];
      end
      for (int i = 0; i < NUM_TMR; i++) begin
         if (next_st.t[i].irq) next_st.sts[i] = 1'b1; // set wins over clear
      end
      next_st.irq = |(next_st.sts & next_st.msk);
      if (access) begin
         next_st.rdata = {24'h000000, rb};
         next_st.err = !hit;
      end
   end

   // State register
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         st <= '0;
         for (int i = 0; i < NUM_TMR; i++) begin
            st.t[i].reload <= `RPCT_RST_RELOAD;
            st.t[i].count <= `RPCT_START_COUNT;
            st.t[i].db_st <= RPCT_DB_IDLE;
         end
      end else begin
         st <= next_st;
      end
   end

   // Outputs from flip-flops, except tmr_comp_oe decoded from the mode bits
   always_comb begin
      prdata = st.rdata;
      pready = st.ready;
      pslverr = st.err;
      irq = st.irq;
      for (int i = 0; i < NUM_TMR; i++) begin
         tmr_out[i] = st.t[i].out_a;
         tmr_comp_out[i] = st.t[i].out_b;
         tmr_irq_pulse[i] = st.t[i].irq;
         tmr_comp_oe[i] = {st.t[i].ctl0[`RPCT_C0_MODE_MSB],
            st.t[i].ctl1[`RPCT_C1_MODE_HI:`RPCT_C1_MODE_LO]} == RPCT_PWM_DUAL;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   irq_pulse_single_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tmr_irq_pulse[0] |=> !tmr_irq_pulse[0]) else $error("irq pulse too long");
   dual_never_both_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !(tmr_out[0] && tmr_comp_out[0] && tmr_comp_oe[0]))
      else $error("both dual outputs high");
   cap_flag_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (psel && penable && pwrite && pready && paddr == `RPCT_T0_CONTROL_ZERO
      && !tmr_irq_pulse[0] && !st.t[0].irq) |=> $stable(st.t[0].ctl0[`RPCT_C0_CAP]))
      else $error("capture flag written");
   apb_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (psel && penable && !pready) |=> pready) else $error("apb answer late");
   irq_level_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tmr_irq_pulse[0] && st.msk[0] |-> ##1 irq) else $error("irq not raised");
   comp_oe_mode_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      tmr_comp_oe[1] |-> st.t[1].ctl0[`RPCT_C0_MODE_MSB]) else $error("oe in wrong mode");
   capture_copy_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (tmr_irq_pulse[0] && st.t[0].ctl0[`RPCT_C0_CAP]) |-> st.t[0].match == $past(st.t[0].count))
      else $error("capture value wrong");
   reload_start_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      (st.t[0].ctl1[`RPCT_C1_EN] && st.t[0].count == st.t[0].reload && st.t[0].pre ==
      7'((8'h01 << st.t[0].ctl1[`RPCT_C1_PRE_HI:`RPCT_C1_PRE_LO]) - 8'h01) &&
      st.t[0].ctl1[`RPCT_C1_MODE_HI:`RPCT_C1_MODE_LO] == 3'h1 && !st.t[0].ctl0[7] && !pready
      && !psel) |=> st.t[0].count == `RPCT_START_COUNT) else $error("no reload");
endmodule // rpct_timer
`default_nettype wire

/* shared/rpct_regs.svh */
// Register offsets, field positions, interrupt configuration codes and reset values of the timer block
`ifndef RPCT_REGS_SVH
`define RPCT_REGS_SVH
`define RPCT_T0_MATCH_HIGH 12'hF04
`define RPCT_T0_MATCH_LOW 12'hF05
`define RPCT_T0_CONTROL_ZERO 12'hF06
`define RPCT_T0_CONTROL_ONE 12'hF07
`define RPCT_T0_RELOAD_HIGH 12'hF08
`define RPCT_T0_RELOAD_LOW 12'hF09
`define RPCT_T0_COUNT_HIGH 12'hF0A
`define RPCT_T0_COUNT_LOW 12'hF0B
`define RPCT_T1_MATCH_HIGH 12'hF0C
`define RPCT_T1_MATCH_LOW 12'hF0D
`define RPCT_T1_CONTROL_ZERO 12'hF0E
`define RPCT_T1_CONTROL_ONE 12'hF0F
`define RPCT_T1_RELOAD_HIGH 12'hF10
`define RPCT_T1_RELOAD_LOW 12'hF11
`define RPCT_T1_COUNT_HIGH 12'hF12
`define RPCT_T1_COUNT_LOW 12'hF13
`define RPCT_IRQ_STATUS 12'hF20
`define RPCT_IRQ_MASK 12'hF24
// Control register zero fields
`define RPCT_C0_MODE_MSB 7
`define RPCT_C0_CFG_HI 6
`define RPCT_C0_CFG_LO 5
`define RPCT_C0_DB_HI 3
`define RPCT_C0_DB_LO 1
`define RPCT_C0_CAP 0
`define RPCT_C0_WMASK 8'hFE
// Control register one fields
`define RPCT_C1_EN 7
`define RPCT_C1_POL 6
`define RPCT_C1_PRE_HI 5
`define RPCT_C1_PRE_LO 3
`define RPCT_C1_MODE_HI 2
`define RPCT_C1_MODE_LO 0
// Interrupt configuration codes
`define RPCT_CFG_CAPTURE 2'h2
`define RPCT_CFG_RELOAD 2'h3
// Reset values
`define RPCT_RST_BYTE 8'h00
`define RPCT_RST_WORD 16'h0000
`define RPCT_RST_RELOAD 16'hFFFF
`define RPCT_START_COUNT 16'h0001
`endif

/* shared/rpct_pkg.sv */
// Types shared by the timer block
package rpct_pkg;
   // Timer operating modes: {mode_select_msb, mode_select_field}
   typedef enum logic [3:0] {
      RPCT_ONE_SHOT = 4'h0,
      RPCT_CONTINUOUS = 4'h1,
      RPCT_COUNTER = 4'h2,
      RPCT_PWM_SINGLE = 4'h3,
      RPCT_CAPTURE = 4'h4,
      RPCT_COMPARE = 4'h5,
      RPCT_GATED = 4'h6,
      RPCT_CAPT_CMP = 4'h7,
      RPCT_PWM_DUAL = 4'h8
   } rpct_mode_t;
   // Deadband sequencer states, one-hot
   typedef enum logic [2:0] {
      RPCT_DB_IDLE = 3'h1,
      RPCT_DB_WAIT = 3'h2,
      RPCT_DB_RUN = 3'h4
   } rpct_db_t;
   // Per-timer registers
   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [15:0] match;
      logic [15:0] reload;
      logic [15:0] count;
      logic [6:0] pre;
      logic pin_q;
      logic pwm;
      logic out_a;
      logic out_b;
      rpct_db_t db_st;
      logic [2:0] db_cnt;
      logic irq;
      logic oneshot_done;
   } rpct_tmr_t;
   // Timer pins
   typedef struct packed {
      logic out;
      logic comp_out;
      logic comp_oe;
   } rpct_pins_t;
endpackage

/* bench/rpct_pin_model.sv */
// Pin-side model of the two timer input pins
`timescale 1ns/10ps
`default_nettype none
module rpct_pin_model (
   // Clock
   input wire logic clk_sys,
   // Timer pins
   input wire logic [1:0] tmr_out,
   input wire logic [1:0] comp_out,
   input wire logic [1:0] comp_oe,
   output logic [1:0] pin,
   // Cycles with both outputs high
   output int overlap
);
   logic [1:0] drv = 2'h0;
   initial overlap = 0;
   // Wire level: the timer owns the pin while it drives it
   assign pin = (comp_oe & comp_out) | (~comp_oe & drv);
   // Count cycles where true and inverted outputs overlap
   always @(posedge clk_sys) begin
      if (|(comp_oe & tmr_out & comp_out)) begin
         overlap <= overlap + 1;
      end
   end
   // Each level held four cycles, so the pin toggles slowly enough
   task automatic pulses(input int t, input int n);
      repeat (n) begin
         repeat (4) @(posedge clk_sys);
         drv[t] <= 1'b1;
         repeat (4) @(posedge clk_sys);
         drv[t] <= 1'b0;
      end
   endtask
endmodule // rpct_pin_model
`default_nettype wire

/* bench/rpct_timer_tb.sv */
// Self-checking testbench of the timer block
`timescale 1ns/10ps
`default_nettype none
`include "rpct_regs.svh"
module rpct_timer_tb;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq;
   logic [1:0] tmr_in, tmr_out, comp_out, comp_oe, irq_p;
   int n_mismatch = 0;
   int cmp_count = 0;
   int overlap;
   // Clock, 20 ns period
   always #10 clk_sys = ~clk_sys;
   rpct_timer #(.NUM_TMR(2)) dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tmr_in(tmr_in), .tmr_out(tmr_out),
      .tmr_comp_out(comp_out), .tmr_comp_oe(comp_oe), .tmr_irq_pulse(irq_p), .irq(irq));
   rpct_pin_model pin_u (.clk_sys(clk_sys), .tmr_out(tmr_out), .comp_out(comp_out),
      .comp_oe(comp_oe), .pin(tmr_in), .overlap(overlap));
   // Compare and count
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer, held until pready is sampled high
   task apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
            output logic [7:0] rd, output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(32'(n < 20), 32'h1);
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      logic [7:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task rd_chk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] r;
      logic e;
      apb(1'b0, a, 8'h00, r, e);
      chk({24'h0, r}, {24'h0, exp});
   endtask
   function automatic logic [11:0] ta(input int t, input logic [11:0] a);
      return a + 12'(8 * t);
   endfunction
   // Stop a timer, load reload, match and count, then start it
   task setup(input int t, input logic [7:0] c0, input logic [7:0] c1,
              input logic [15:0] rl, input logic [15:0] m);
      wr(ta(t, `RPCT_T0_CONTROL_ONE), 8'h00);
      wr(ta(t, `RPCT_T0_RELOAD_HIGH), rl[15:8]);
      wr(ta(t, `RPCT_T0_RELOAD_LOW), rl[7:0]);
      wr(ta(t, `RPCT_T0_MATCH_HIGH), m[15:8]);
      wr(ta(t, `RPCT_T0_MATCH_LOW), m[7:0]);
      wr(ta(t, `RPCT_T0_COUNT_HIGH), 8'h00);
      wr(ta(t, `RPCT_T0_COUNT_LOW), 8'h01);
      wr(ta(t, `RPCT_T0_CONTROL_ZERO), c0);
      wr(ta(t, `RPCT_T0_CONTROL_ONE), c1);
   endtask
   // Edges until the interrupt pulse of timer t is seen
   task wait_irq(input int t, output int n);
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (irq_p[t] !== 1'b1 && n < 2000);
      chk(32'(n < 2000), 32'h1);
   endtask
   // Reset values, read-only flag and an unmapped address
   task regs_test;
      logic [7:0] r;
      logic e;
      for (int t = 0; t < 2; t++) begin
         rd_chk(ta(t, `RPCT_T0_MATCH_HIGH), 8'h00);
         rd_chk(ta(t, `RPCT_T0_MATCH_LOW), 8'h00);
         rd_chk(ta(t, `RPCT_T0_CONTROL_ZERO), 8'h00);
         rd_chk(ta(t, `RPCT_T0_RELOAD_HIGH), 8'hFF);
         rd_chk(ta(t, `RPCT_T0_COUNT_LOW), 8'h01);
         wr(ta(t, `RPCT_T0_CONTROL_ZERO), 8'hFF);
         rd_chk(ta(t, `RPCT_T0_CONTROL_ZERO), 8'hFE);
         wr(ta(t, `RPCT_T0_CONTROL_ZERO), 8'h00);
         wr(ta(t, `RPCT_T0_MATCH_HIGH), 8'hA5);
         rd_chk(ta(t, `RPCT_T0_MATCH_HIGH), 8'hA5);
      end
      apb(1'b0, 12'hF30, 8'h00, r, e);
      chk({31'h0, e}, 32'h1);
      chk({24'h0, r}, 32'h0);
      $display("test regs done");
   endtask
   // Reload period, prescale, one-cycle pulse, status, mask and clear
   task reload_test(input int t, input int pre);
      int n;
      setup(t, 8'h60, {2'b10, 3'(pre), 3'h1}, 16'h0004, 16'hFFFF);
      wait_irq(t, n);
      @(posedge clk_sys);
      chk({31'h0, irq_p[t]}, 32'h0);
      wait_irq(t, n);
      chk(32'(n), 32'((4 << pre) - 1));
      rd_chk(ta(t, `RPCT_T0_CONTROL_ZERO), 8'h60);
      rd_chk(`RPCT_IRQ_STATUS, 8'(1 << t));
      chk({31'h0, irq}, 32'h0);
      wr(`RPCT_IRQ_MASK, 8'(1 << t));
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h1);
      wr(ta(t, `RPCT_T0_CONTROL_ONE), 8'h00);
      wr(`RPCT_IRQ_STATUS, 8'(1 << t));
      repeat (2) @(posedge clk_sys);
      chk({31'h0, irq}, 32'h0);
      rd_chk(`RPCT_IRQ_STATUS, 8'h00);
      wr(`RPCT_IRQ_MASK, 8'h00);
      $display("test reload done");
   endtask
   // Pin edge captures the count into the match registers
   task cap_test;
      int n;
      logic [7:0] h, l;
      logic e;
      setup(0, 8'h40, 8'h84, 16'hFFFF, 16'h0000);
      fork
         pin_u.pulses(0, 1);
         wait_irq(0, n);
      join
      rd_chk(`RPCT_T0_CONTROL_ZERO, 8'h41);
      apb(1'b0, `RPCT_T0_MATCH_HIGH, 8'h00, h, e);
      apb(1'b0, `RPCT_T0_MATCH_LOW, 8'h00, l, e);
      chk(32'({h, l} != 16'h0000), 32'h1);
      $display("test capture done");
   endtask
   // Pin pulses counted as the timer source
   task count_test;
      setup(0, 8'h00, 8'h82, 16'hFFFF, 16'hFFFF);
      pin_u.pulses(0, 5);
      repeat (8) @(posedge clk_sys);
      rd_chk(`RPCT_T0_COUNT_HIGH, 8'h00);
      rd_chk(`RPCT_T0_COUNT_LOW, 8'h06);
      $display("test counter done");
   endtask
   // Every mode code; only the dual mode drives the shared pin
   task mode_test;
      logic [3:0] m;
      for (int i = 0; i < 9; i++) begin
         m = 4'(i);
         wr(`RPCT_T0_CONTROL_ZERO, {m[3], 7'h00});
         wr(`RPCT_T0_CONTROL_ONE, {5'h10, m[2:0]});
         repeat (3) @(posedge clk_sys);
         chk({31'h0, comp_oe[0]}, 32'(i == 8));
      end
      $display("test modes done");
   endtask
   // One output period per reload cycle, never overlapping in dual mode
   task pwm_test(input logic [7:0] c0, input logic [7:0] c1);
      int r;
      logic p;
      setup(0, c0, c1, 16'h0008, 16'h0004);
      r = 0;
      p = tmr_out[0];
      repeat (160) begin
         @(posedge clk_sys);
         if (tmr_out[0] === 1'b1 && p === 1'b0) r++;
         p = tmr_out[0];
      end
      chk(32'(r >= 19 && r <= 21), 32'h1);
      chk({31'h0, comp_oe[0]}, 32'(c0[7]));
      chk(32'(overlap), 32'h0);
      $display("test pwm done");
   endtask
   // Verdict
   task test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      regs_test;
      reload_test(0, 0);
      reload_test(1, 7);
      cap_test;
      count_test;
      mode_test;
      pwm_test(8'h00, 8'h83);
      pwm_test(8'h00, 8'hC3);
      pwm_test(8'h82, 8'h80);
      test_done;
   end
   // Watchdog
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_mismatch++;
      test_done;
   end
endmodule // rpct_timer_tb
`default_nettype wire
